// file: design/mws_pkg.sv
// Constants, types and register map of the multi-word shift unit
package mws_pkg;

  // Datapath geometry
  localparam int WORD_W    = 16;
  localparam int MEM_DEPTH = 16;
  localparam int ADDR_W    = 4;
  localparam int PADDR_W   = 8;

  // APB register offsets (byte addresses)
  localparam logic [PADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_CWORD  = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_RANGE  = 8'h08;
  localparam logic [PADDR_W-1:0] OFF_SRC    = 8'h0c;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h10;
  // Data words occupy 8'h40..8'h7c
  localparam logic [1:0]         MEM_PAGE   = 2'h1;

  // Command register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO_BIT = 8;

  // Control word bits of the reversible bit shift
  localparam int CW_CLEAR_BIT = 15;
  localparam int CW_TRIG_BIT  = 14;
  localparam int CW_DATA_BIT  = 13;
  localparam int CW_DIR_BIT   = 12;

  // Range register fields
  localparam int RANGE_ST_LSB = 0;
  localparam int RANGE_EN_LSB = 8;

  // Reset values and the one-word address step
  localparam logic [WORD_W-1:0] CWORD_RST = 16'h0000;
  localparam logic [WORD_W-1:0] SRC_RST   = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RST  = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ONE  = 4'h1;

  typedef enum logic [1:0] {MWS_OP_REV, MWS_OP_WORD, MWS_OP_ASL, MWS_OP_NONE} mws_op_t;
  typedef enum logic [1:0] {ACT_CLEAR, ACT_LEFT, ACT_RIGHT, ACT_WORD} mws_act_t;
  typedef enum logic {S_IDLE, S_RUN} mws_state_t;

  typedef struct packed {
    logic negative;
    logic zero;
    logic carry;
    logic error;
  } mws_flags_t;

  localparam mws_flags_t FLAGS_RST = 4'h0;

endpackage : mws_pkg

// file: design/mws_bit_stage.sv
// One-bit shifter of a single word with insert and spill bits
`timescale 1ns/1ps
`default_nettype none
module mws_bit_stage
  import mws_pkg::*;
(
  input  wire logic [WORD_W-1:0] wordIn,
  input  wire logic              insertBit,
  input  wire logic              shiftRight,
  output logic      [WORD_W-1:0] wordOut,
  output logic                   outBit
);

  assign wordOut = shiftRight ? {insertBit, wordIn[WORD_W-1:1]} : {wordIn[WORD_W-2:0], insertBit};
  assign outBit  = shiftRight ? wordIn[0] : wordIn[WORD_W-1];

endmodule : mws_bit_stage
`default_nettype wire

// file: design/mws_shift_unit.sv
// Multi-word shift unit: reversible bit shift, word shift, arithmetic left shift
// How it works
// - A reversible shift moves the whole range by one bit only on a rising edge of control bit 14.
// - Control bit 12 picks the direction, one for right and zero for left.
// - With control bit 15 set the range and the carry are cleared and any shift is ignored.
// - A left shift feeds control bit 13 into bit 0 of the start word and spills end bit 15 into carry.
// - A right shift feeds control bit 13 into bit 15 of the end word and spills start bit 0 into carry.
// - The carry after a reversible shift is the spilled bit, and a clear zeroes it.
// - Both range operations set the error flag when start exceeds end and clear it otherwise.
// - A word shift moves each word one place toward the end, puts the source in the start and drops the end.
// - An arithmetic left shift moves one word left, inserts zero and copies the old top bit into carry.
// - After it the zero flag shows whether the result is all zeros.
// - After it the negative flag copies result bit 15 and carry is set only when a one left.
`timescale 1ns/1ps
`default_nettype none
module mws_shift_unit
  import mws_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output mws_flags_t              flags,
  output logic                    busy
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [WORD_W-1:0] mem_q [MEM_DEPTH];
  logic [WORD_W-1:0] ctrlWord_q;
  logic [WORD_W-1:0] srcWord_q;
  logic [ADDR_W-1:0] stAddr_q;
  logic [ADDR_W-1:0] enAddr_q;
  logic [ADDR_W-1:0] idx_q;
  logic              inBit_q;
  logic              trigPrev_q;
  logic              settled_q;
  logic [31:0]       prdata_q;
  mws_flags_t        flags_q;
  mws_state_t        state_q;
  mws_act_t          act_q;

  function automatic logic isMemAddr(input logic [PADDR_W-1:0] a);
    isMemAddr = (a[PADDR_W-1:PADDR_W-2] == MEM_PAGE);
  endfunction : isMemAddr

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic              accessPhase;
  logic              wrEn;
  logic              addrHit;
  logic [ADDR_W-1:0] memIdx;
  logic              goReq;
  mws_op_t           goOp;
  logic              goRev;
  logic              goWord;
  logic              goAsl;
  logic [31:0]       readData;

  assign accessPhase = psel & penable;
  // Wait states while a range operation walks the data words and for one cycle after it ends
  assign pready      = penable & settled_q;
  assign wrEn        = accessPhase & pready & pwrite;
  assign memIdx      = paddr[ADDR_W+1:2];
  assign addrHit     = isMemAddr(paddr) | (paddr == OFF_CTRL) | (paddr == OFF_CWORD) |
                       (paddr == OFF_RANGE) | (paddr == OFF_SRC) | (paddr == OFF_STATUS);
  assign pslverr     = accessPhase & pready & ~addrHit;
  assign goReq       = wrEn & (paddr == OFF_CTRL) & pwdata[CTRL_GO_BIT];
  assign goOp        = mws_op_t'(pwdata[CTRL_OP_LSB +: 2]);
  assign goRev       = goReq & (goOp == MWS_OP_REV);
  assign goWord      = goReq & (goOp == MWS_OP_WORD);
  assign goAsl       = goReq & (goOp == MWS_OP_ASL);
  assign busy        = (state_q == S_RUN);
  assign flags       = flags_q;
  assign prdata      = prdata_q;

  assign readData = isMemAddr(paddr)      ? {16'h0000, mem_q[memIdx]} :
                    (paddr == OFF_CWORD)  ? {16'h0000, ctrlWord_q} :
                    (paddr == OFF_RANGE)  ? {20'h00000, enAddr_q, 4'h0, stAddr_q} :
                    (paddr == OFF_SRC)    ? {16'h0000, srcWord_q} :
                    (paddr == OFF_STATUS) ? {27'h0000000, flags_q, busy} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Launch decisions
  logic     rangeErr;
  logic     clearReq;
  logic     trigEdge;
  logic     revLaunch;
  logic     wordLaunch;
  mws_act_t nextAct;
  logic     startAtEnd;

  assign rangeErr   = stAddr_q > enAddr_q;
  assign clearReq   = ctrlWord_q[CW_CLEAR_BIT];
  assign trigEdge   = ctrlWord_q[CW_TRIG_BIT] & ~trigPrev_q;
  assign revLaunch  = goRev & ~rangeErr & (clearReq | trigEdge);
  assign wordLaunch = goWord & ~rangeErr;
  assign nextAct    = goWord ? ACT_WORD :
                      clearReq ? ACT_CLEAR :
                      ctrlWord_q[CW_DIR_BIT] ? ACT_RIGHT : ACT_LEFT;
  assign startAtEnd = (nextAct == ACT_RIGHT) | (nextAct == ACT_WORD);

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  logic [WORD_W-1:0] stageIn;
  logic              stageIns;
  logic              stageRight;
  logic [WORD_W-1:0] stageOut;
  logic              stageOutBit;
  logic              running;
  logic              lastStep;
  logic              walkUp;
  logic [WORD_W-1:0] wordShiftVal;
  logic [WORD_W-1:0] stepValue;

  assign running    = (state_q == S_RUN);
  // Idle: the stage serves the single-word arithmetic shift at the start address
  assign stageIn    = running ? mem_q[idx_q] : mem_q[stAddr_q];
  assign stageIns   = running & inBit_q;
  assign stageRight = running & (act_q == ACT_RIGHT);
  assign walkUp     = (act_q == ACT_LEFT) | (act_q == ACT_CLEAR);
  assign lastStep   = walkUp ? (idx_q == enAddr_q) : (idx_q == stAddr_q);
  // Walking down from the end keeps each moved word unread-after-write
  assign wordShiftVal = (idx_q == stAddr_q) ? srcWord_q : mem_q[idx_q - ADDR_ONE];
  assign stepValue  = (act_q == ACT_CLEAR) ? WORD_RST :
                      (act_q == ACT_WORD) ? wordShiftVal : stageOut;

  mws_bit_stage u_stage (
    .wordIn     (stageIn),
    .insertBit  (stageIns),
    .shiftRight (stageRight),
    .wordOut    (stageOut),
    .outBit     (stageOutBit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrlWord_q <= CWORD_RST;
      srcWord_q  <= SRC_RST;
      stAddr_q   <= ADDR_RST;
      enAddr_q   <= ADDR_RST;
    end else if (wrEn) begin
      if (paddr == OFF_CWORD) ctrlWord_q <= pwdata[WORD_W-1:0];
      if (paddr == OFF_SRC) srcWord_q <= pwdata[WORD_W-1:0];
      if (paddr == OFF_RANGE) begin
        stAddr_q <= pwdata[RANGE_ST_LSB +: ADDR_W];
        enAddr_q <= pwdata[RANGE_EN_LSB +: ADDR_W];
      end
    end
  end

  // Read data is sampled a cycle early so prdata comes from a flop
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      settled_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      settled_q <= psel & ~busy & ~(accessPhase & settled_q);
      prdata_q  <= readData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, data words and flags
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_q[i] <= WORD_RST;
      end
      state_q    <= S_IDLE;
      act_q      <= ACT_CLEAR;
      idx_q      <= ADDR_RST;
      inBit_q    <= 1'b0;
      trigPrev_q <= 1'b0;
      flags_q    <= FLAGS_RST;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (wrEn & isMemAddr(paddr)) mem_q[memIdx] <= pwdata[WORD_W-1:0];
          if (goRev | goWord) flags_q.error <= rangeErr;
          if (goRev & ~rangeErr) trigPrev_q <= ctrlWord_q[CW_TRIG_BIT];
          if (revLaunch & clearReq) flags_q.carry <= 1'b0;
          if (revLaunch | wordLaunch) begin
            state_q <= S_RUN;
            act_q   <= nextAct;
            idx_q   <= startAtEnd ? enAddr_q : stAddr_q;
            inBit_q <= ctrlWord_q[CW_DATA_BIT];
          end
          if (goAsl) begin
            mem_q[stAddr_q]  <= stageOut;
            flags_q.error    <= 1'b0;
            flags_q.carry    <= stageOutBit;
            flags_q.zero     <= (stageOut == WORD_RST);
            flags_q.negative <= stageOut[WORD_W-1];
          end
        end
        S_RUN: begin
          mem_q[idx_q] <= stepValue;
          inBit_q      <= stageOutBit;
          if (lastStep) begin
            state_q <= S_IDLE;
            if (act_q == ACT_LEFT || act_q == ACT_RIGHT) flags_q.carry <= stageOutBit;
          end else begin
            idx_q <= walkUp ? idx_q + ADDR_ONE : idx_q - ADDR_ONE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Steps of the running walk, so its length can be held against the range
  logic [ADDR_W-1:0] stepCnt_q;

  always_ff @(posedge clk_sys) begin
    if (reset || !running) begin
      stepCnt_q <= ADDR_RST;
    end else begin
      stepCnt_q <= stepCnt_q + ADDR_ONE;
    end
  end

  sequence aslIssue;
    goAsl && !running;
  endsequence

  sequence revShiftIssue;
    revLaunch && !clearReq;
  endsequence

  sequence leftFinal;
    running && act_q == ACT_LEFT && lastStep;
  endsequence

  sequence rightFinal;
    running && act_q == ACT_RIGHT && lastStep;
  endsequence

  sequence clearFinal;
    running && act_q == ACT_CLEAR && lastStep;
  endsequence

  sequence wordFinal;
    running && act_q == ACT_WORD && lastStep;
  endsequence

  aslCarry_a: assert property (aslIssue |=> flags_q.carry == $past(stageIn[WORD_W-1]))
    else $error("carry does not hold the old top bit after the arithmetic shift");
  aslZero_a: assert property (aslIssue |=> flags_q.zero == ($past(stageIn[WORD_W-2:0]) == 15'h0000))
    else $error("zero flag wrong after the arithmetic shift");
  aslNeg_a: assert property (aslIssue |=> flags_q.negative == $past(stageIn[WORD_W-2]))
    else $error("negative flag wrong after the arithmetic shift");
  rangeErr_a: assert property ((goRev || goWord) |=> flags_q.error == $past(rangeErr))
    else $error("error flag does not follow the range check");
  errHold_a: assert property ((goRev || goWord) && rangeErr |=> !running)
    else $error("range operation started despite a range error");
  clearCarry_a: assert property (revLaunch && clearReq |=> !flags_q.carry && act_q == ACT_CLEAR)
    else $error("clear did not zero the carry or picked a shift");
  noTrig_a: assert property (goRev && !clearReq && !trigEdge |=> !running)
    else $error("reversible shift ran without a trigger edge");
  dirSel_a: assert property (revShiftIssue |=>
                             act_q == ($past(ctrlWord_q[CW_DIR_BIT]) ? ACT_RIGHT : ACT_LEFT))
    else $error("shift direction does not follow control bit 12");
  leftSpill_a: assert property (leftFinal |=> !running && flags_q.carry == $past(stageIn[WORD_W-1]))
    else $error("left shift did not spill end bit 15 into carry");
  rightSpill_a: assert property (rightFinal |=> !running && flags_q.carry == $past(stageIn[0]))
    else $error("right shift did not spill start bit 0 into carry");
  feedIn_a: assert property (revShiftIssue |=> inBit_q == $past(ctrlWord_q[CW_DATA_BIT]))
    else $error("data input bit not loaded as the first insert bit");
  wordWalk_a: assert property (running && act_q == ACT_WORD && !lastStep |=> idx_q == $past(idx_q) - ADDR_ONE)
    else $error("word shift does not walk from end toward start");
  busyWait_a: assert property (running && penable |-> !pready)
    else $error("bus answered while the range walk was busy");
  leftWord_a: assert property (leftFinal |=> mem_q[idx_q] == $past({stageIn[WORD_W-2:0], inBit_q}))
    else $error("left shift wrote a wrong end word");
  rightWord_a: assert property (rightFinal |=> mem_q[idx_q] == $past({inBit_q, stageIn[WORD_W-1:1]}))
    else $error("right shift wrote a wrong start word");
  clearWord_a: assert property (clearFinal |=> mem_q[idx_q] == WORD_RST)
    else $error("clear left a nonzero word in the range");
  srcWord_a: assert property (wordFinal |=> mem_q[idx_q] == srcWord_q)
    else $error("word shift did not put the source word at the start");
  walkStart_a: assert property (revShiftIssue |=>
                                idx_q == ($past(ctrlWord_q[CW_DIR_BIT]) ? $past(enAddr_q) : $past(stAddr_q)))
    else $error("reversible walk started at the wrong end of the range");
  wordStart_a: assert property (wordLaunch |=> running && act_q == ACT_WORD && idx_q == $past(enAddr_q))
    else $error("word shift did not start at the end word");
  walkLen_a: assert property (running && lastStep |-> stepCnt_q == enAddr_q - stAddr_q)
    else $error("range walk length differs from the range size");
  clearWalk_a: assert property (running && act_q == ACT_CLEAR && !lastStep |=> idx_q == $past(idx_q) + ADDR_ONE)
    else $error("clear does not walk from start toward end");

endmodule : mws_shift_unit
`default_nettype wire

// file: verif/mws_apb_host.sv
// APB host model standing in for the instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module mws_apb_host
  import mws_pkg::*;
(
  input  wire logic               clk_sys,
  output logic                    psel,
  output logic                    penable,
  output logic                    pwrite,
  output logic      [PADDR_W-1:0] paddr,
  output logic      [31:0]        pwdata,
  input  wire logic [31:0]        prdata,
  input  wire logic               pready,
  input  wire logic               pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  ////////////////////////////////////////////////////////////////
  // No bound here: the bench timeout cuts a hang
  task automatic xfer(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Inverted leftovers, so a stale value never looks valid
    paddr <= ~a;
    pwdata <= ~wd;
  endtask : xfer
endmodule : mws_apb_host
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench of the multi-word shift unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mws_pkg::*;
  localparam int LIMIT = 6000;
  logic               clk_sys;
  logic               reset;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic [31:0]        rdata;
  logic [31:0]        statusQ;
  logic               pready;
  logic               pslverr;
  logic               slvErr;
  mws_flags_t         flags;
  logic               busy;
  int                 errCount;
  int                 samplesChecked;
  int                 cycles;
  logic [15:0]        aslIn  [4] = '{16'h8001, 16'h4000, 16'h8000, 16'h1234};
  logic [15:0]        aslOut [4] = '{16'h0002, 16'h8000, 16'h0000, 16'h2468};
  logic [3:0]         aslFlg [4] = '{4'h2, 4'h8, 4'h6, 4'h0};

  mws_shift_unit mws_shift_unit_inst (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flags(flags), .busy(busy));
  mws_apb_host mws_apb_host_inst (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      errCount++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      errCount++;
    end
  endtask : chk
  task automatic wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
    mws_apb_host_inst.xfer(1'b1, a, d, rdata, slvErr);
  endtask : wr
  task automatic rdw(input logic [PADDR_W-1:0] a);
    mws_apb_host_inst.xfer(1'b0, a, 32'h0000_0000, rdata, slvErr);
  endtask : rdw
  task automatic setw(input logic [3:0] i, input logic [15:0] v);
    wr({MEM_PAGE, i, 2'b00}, {16'h0000, v});
  endtask : setw
  task automatic chkw(input logic [3:0] i, input logic [15:0] e);
    rdw({MEM_PAGE, i, 2'b00});
    chk("data word", {16'h0000, e}, rdata);
  endtask : chkw
  // Ranges stay inside the 16-word area by construction of the 4-bit fields
  task automatic op(input mws_op_t o, input logic [3:0] st, input logic [3:0] en);
    wr(OFF_RANGE, {20'h00000, en, 4'h0, st});
    wr(OFF_CTRL, {23'h000000, 1'b1, 6'h00, o});
    rdw(OFF_STATUS);
    statusQ = rdata;
    chk("busy after walk", 32'h0, {31'h0, statusQ[0]});
  endtask : op
  task automatic chkFlags(input logic [3:0] exp, input logic [3:0] mask);
    chk("flags port", {28'h0, exp & mask}, {28'h0, flags & mask});
    chk("status flags", {28'h0, exp & mask}, {28'h0, statusQ[4:1] & mask});
  endtask : chkFlags
  ////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    errCount = 0;
    samplesChecked = 0;
    cycles = 0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("reset flags", 32'h0, {28'h0, flags});
    chk("reset busy", 32'h0, {31'h0, busy});
    chkw(4'h0, 16'h0000);
    // Arithmetic left shift table
    for (int i = 0; i < 4; i++) begin
      setw(4'(i), aslIn[i]);
      // Operand word sits at the start address of the range
      op(MWS_OP_ASL, 4'(i), 4'(i));
      chkw(4'(i), aslOut[i]);
      chkFlags(aslFlg[i], 4'hf);
    end
    // Reversible shift, left then repeated go without a new trigger edge
    setw(4'h2, 16'h8001);
    setw(4'h3, 16'h0000);
    setw(4'h4, 16'h8000);
    wr(OFF_CWORD, 32'h0000_6000);
    op(MWS_OP_REV, 4'h2, 4'h4);
    chkw(4'h2, 16'h0003);
    chkw(4'h3, 16'h0001);
    chkw(4'h4, 16'h0000);
    chkFlags(4'h2, 4'h3);
    op(MWS_OP_REV, 4'h2, 4'h4);
    chkw(4'h2, 16'h0003);
    // Right shift with data-in one, spilled bit zero
    setw(4'h2, 16'h0002);
    wr(OFF_CWORD, 32'h0000_0000);
    op(MWS_OP_REV, 4'h2, 4'h4);
    wr(OFF_CWORD, 32'h0000_7000);
    op(MWS_OP_REV, 4'h2, 4'h4);
    chkw(4'h2, 16'h8001);
    chkw(4'h3, 16'h0000);
    chkw(4'h4, 16'h8000);
    chkFlags(4'h0, 4'h3);
    // Clear with a live trigger edge and carry set beforehand
    setw(4'h9, 16'h8000);
    op(MWS_OP_ASL, 4'h9, 4'h9);
    wr(OFF_CWORD, 32'h0000_0000);
    op(MWS_OP_REV, 4'h2, 4'h4);
    wr(OFF_CWORD, 32'h0000_c000);
    op(MWS_OP_REV, 4'h2, 4'h4);
    chkw(4'h2, 16'h0000);
    chkw(4'h4, 16'h0000);
    chkFlags(4'h0, 4'h3);
    // Range error on both range operations
    setw(4'h3, 16'h5a5a);
    op(MWS_OP_REV, 4'h4, 4'h3);
    chkFlags(4'h1, 4'h1);
    chkw(4'h3, 16'h5a5a);
    op(MWS_OP_WORD, 4'h4, 4'h3);
    chkFlags(4'h1, 4'h1);
    chkw(4'h3, 16'h5a5a);
    // Word shift, the word past the end untouched
    setw(4'h5, 16'h1111);
    setw(4'h6, 16'h2222);
    setw(4'h7, 16'h3333);
    setw(4'h8, 16'h4444);
    wr(OFF_SRC, 32'h0000_abcd);
    op(MWS_OP_WORD, 4'h5, 4'h7);
    chkw(4'h5, 16'habcd);
    chkw(4'h6, 16'h1111);
    chkw(4'h7, 16'h2222);
    chkw(4'h8, 16'h4444);
    chkFlags(4'h0, 4'h1);
    // Unmapped address
    rdw(8'h20);
    chk("unmapped error", 32'h1, {31'h0, slvErr});
    chk("unmapped data", 32'h0, rdata);
    summarize();
  end
endmodule : testbench
`default_nettype wire
